// ### rmcfg_map.svh
// Constants for the resource monitor configuration block: register
// indices, field positions, write masks and reset values.
// Assumes it is included by the package and by each design module.
// How it works
// R1: Identity register reports how many monitor instances exist, read-only.
// R2: Filter, control and count accesses go to the instance named by select.
// R3: One 32-bit filter and one 32-bit control register per instance.
// R4: Unused configuration fields read as zero and ignore writes.
// R5: Filter bits 15:0 hold partition to match; bits 31:24 read zero.
// R6: Filter bits 23:16 hold group to match when group matching enabled.
// R7: Control bits 7:0 read constant 0x42 naming a bandwidth-usage monitor.
// R8: Control bit 16 set counts only events with matching partition.
// R9: Control bit 17 set counts only events with matching group.
// R10: Control bits 23:20 extra_match_criteria unused here, read zero, ignore writes.
// R11: Bit 24 clear wraps and keeps counting; set freezes post-overflow value.
// R12: Bit 25 set raises interrupt on overflow; clear raises none.
// R13: Bit 26 sticky overflow flag stays set until software writes zero.
// R14: Bit 27 set zeroes the count when a capture occurs.
// R15: Bits 30:28 select capture source; value 0 is external event one.
// R16: Value 7 captures on local trigger write; unimplemented ones never do.
// R17: Bit 31 enables monitor; disabled monitor collects nothing.
// R18: Capture loads count with not-settled bit, then optionally clears count.
// R19: Event counts only when every enabled match succeeds together.
`ifndef RMCFG_MAP_SVH
`define RMCFG_MAP_SVH

// ****************************************************************
// Sizes
// ****************************************************************
`define RMCFG_INSTANCE_COUNT      4
`define RMCFG_SEL_W        2
`define RMCFG_CNT_W        31
`define RMCFG_TYPE_BWU     8'h42

// ****************************************************************
// Register indices on the register port
// ****************************************************************
`define RMCFG_IDX_SELECT   3'h0
`define RMCFG_IDX_FILTER   3'h1
`define RMCFG_IDX_CONTROL  3'h2
`define RMCFG_IDX_COUNT    3'h3
`define RMCFG_IDX_CAPTURE  3'h4
`define RMCFG_IDX_TRIGGER  3'h5
`define RMCFG_IDX_IDENT    3'h6

// ****************************************************************
// Field positions and masks
// ****************************************************************
`define RMCFG_FLT_WMASK    32'h00FF_FFFF
`define RMCFG_CTL_WMASK    32'hFF03_0000
`define RMCFG_CTL_PART_EN  16
`define RMCFG_CTL_GROUP_EN 17
`define RMCFG_CTL_FREEZE   24
`define RMCFG_CTL_INTR     25
`define RMCFG_CTL_STICKY   26
`define RMCFG_CTL_CLEAR    27
`define RMCFG_CTL_TRIG_LSB 28
`define RMCFG_CTL_ENABLE   31
`define RMCFG_CNT_UNSET    31
`define RMCFG_TRIG_NOW     0
`define RMCFG_SRC_LOCAL    7
`define RMCFG_SRC_IMPL     8'h83
`define RMCFG_REG_RST      32'h0000_0000

`endif

// ### rmcfg_pkg.sv
// Types shared by the resource monitor configuration modules.
// Assumes rmcfg_map.svh is on the include path.
`include "rmcfg_map.svh"

package rmcfg_pkg;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef logic [`RMCFG_CNT_W-1:0] rmcfg_count_t;

    // One tagged memory-system request seen by the monitors
    typedef struct packed {
        logic        valid;
        logic [15:0] part;
        logic [7:0]  group;
        logic [7:0]  amount;
    } rmcfg_event_s;

    // Register port request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [2:0]  idx;
        logic [31:0] wdata;
    } rmcfg_req_s;

    // Decoded configuration handed to one counter
    typedef struct packed {
        logic        enable;
        logic        part_en;
        logic        group_en;
        logic        freeze;
        logic        clear_after;
        logic [15:0] part;
        logic [7:0]  group;
    } rmcfg_cfg_s;

endpackage

// ### rmcfg_counter.sv
// One bandwidth-usage counter with capture register.
// Assumes capture_i is already gated by the source select and that
// the sticky overflow flag is kept by the instantiating module.
`timescale 1ns/1ps
`default_nettype none
`include "rmcfg_map.svh"

module rmcfg_counter
(
    // Clock and reset
    input  wire logic                  core_clk_i,
    input  wire logic                  reset_n_i,
    // Configuration and traffic
    input  wire rmcfg_pkg::rmcfg_cfg_s   cfg_i,
    input  wire rmcfg_pkg::rmcfg_event_s evt_i,
    input  wire logic                  sticky_i,
    input  wire logic                  capture_i,
    // Software access to the live count
    input  wire logic                  cnt_wr_i,
    input  wire logic [31:0]           cnt_wdata_i,
    output logic [31:0]                count_o,
    output logic [31:0]                snap_o,
    output logic                       wrap_o
);
    import rmcfg_pkg::*;

    rmcfg_count_t cnt_q, cnt_d, base;
    logic         unset_q, unset_d;
    logic [31:0]  snap_q, snap_d, sum;
    logic [7:0]   inc;
    logic         match, frozen, capt;

    // ************************************************************
    // Event acceptance and arithmetic
    // ************************************************************
    // Enabled matches must all hold at once
    assign match  = evt_i.valid & cfg_i.enable                   // R17
                  & (~cfg_i.part_en | (evt_i.part == cfg_i.part)) // R8
                  & (~cfg_i.group_en | (evt_i.group == cfg_i.group)) // R9 R19
                  ;
    // Frozen from the cycle after the wrap until the flag is cleared
    assign frozen = cfg_i.freeze & sticky_i;                      // R11
    assign inc    = (match & ~frozen) ? evt_i.amount : 8'h00;
    assign capt   = capture_i & cfg_i.enable;                     // R17
    assign base   = (capt & cfg_i.clear_after) ? '0 : cnt_q;      // R14 R18
    assign sum    = {1'b0, base} + {24'h00_0000, inc};
    // Carry out of the count width is the overflow
    assign wrap_o = ~cnt_wr_i & sum[`RMCFG_CNT_W];

    // Next count, not-settled bit and capture value
    always_comb
    begin
        cnt_d   = cnt_q;
        unset_d = unset_q;
        snap_d  = snap_q;
        if (cnt_wr_i)
        begin
            // Software write wins over traffic in the same cycle
            cnt_d   = cnt_wdata_i[`RMCFG_CNT_W-1:0];
            unset_d = cnt_wdata_i[`RMCFG_CNT_UNSET];
        end
        else
        begin
            if (capt)
                snap_d = {unset_q, cnt_q};                        // R18
            // Wrap keeps low bits; frozen value may be nonzero
            cnt_d = sum[`RMCFG_CNT_W-1:0];                        // R11
        end
    end

    // State registers
    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            cnt_q   <= '0;
            unset_q <= 1'b0;
            snap_q  <= `RMCFG_REG_RST;
        end
        else
        begin
            cnt_q   <= cnt_d;
            unset_q <= unset_d;
            snap_q  <= snap_d;
        end
    end

    assign count_o = {unset_q, cnt_q};
    assign snap_o  = snap_q;

    // ************************************************************
    // Checks
    // ************************************************************
    property p_freeze_hold;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (frozen && !cnt_wr_i && !(capt && cfg_i.clear_after))
            |=> $stable(cnt_q);
    endproperty
    a_freeze_hold: assert property (p_freeze_hold) // R11
        else $error("frozen counter moved");

    property p_disabled_idle;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (!cfg_i.enable && !cnt_wr_i) |=> $stable(cnt_q) && $stable(snap_q);
    endproperty
    a_disabled_idle: assert property (p_disabled_idle) // R17
        else $error("disabled monitor collected data");

    property p_capture_load;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (capt && !cnt_wr_i) |=> (snap_q == $past(count_o));
    endproperty
    a_capture_load: assert property (p_capture_load) // R18
        else $error("capture did not load current count");

    property p_clear_after;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (capt && cfg_i.clear_after && !cnt_wr_i && !evt_i.valid)
            |=> (cnt_q == '0);
    endproperty
    a_clear_after: assert property (p_clear_after) // R14
        else $error("count not cleared after capture");

    property p_part_filter;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (cfg_i.part_en && evt_i.part != cfg_i.part && !cnt_wr_i && !capt)
            |=> $stable(cnt_q);
    endproperty
    a_part_filter: assert property (p_part_filter) // R8
        else $error("foreign partition counted");

    property p_group_filter;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (cfg_i.group_en && evt_i.group != cfg_i.group && !cnt_wr_i && !capt)
            |=> $stable(cnt_q);
    endproperty
    a_group_filter: assert property (p_group_filter) // R9
        else $error("foreign group counted");

endmodule
`default_nettype wire

// ### rmcfg_top.sv
// Resource monitor configuration bank with its bandwidth counters.
// Assumes register requests and traffic come from logic on core_clk_i,
// so no synchroniser is placed on them.
`timescale 1ns/1ps
`default_nettype none
`include "rmcfg_map.svh"

module rmcfg_top
(
    // Clock and reset
    input  wire logic                    core_clk_i,
    input  wire logic                    reset_n_i,
    // Register port
    input  wire rmcfg_pkg::rmcfg_req_s   req_i,
    output logic [31:0]                  reg_rdata_o,
    output logic                         reg_rvalid_o,
    // Monitored traffic and capture sources
    input  wire rmcfg_pkg::rmcfg_event_s evt_i,
    input  wire logic [1:0]              ext_capture_i,
    // Overflow interrupt
    output logic                         wrap_irq_o
);
    import rmcfg_pkg::*;

    localparam int NMON = `RMCFG_INSTANCE_COUNT;

    // ************************************************************
    // Helpers
    // ************************************************************
    // True when the chosen source is implemented and fires now
    function automatic logic capt_hit(input logic [2:0] src,
                                      input logic [1:0] ext,
                                      input logic       local_now);
        logic [7:0] fire;
        logic [7:0] impl;
        fire = {local_now, 5'h00, ext};
        // A literal cannot be indexed, so copy the source mask first
        impl = `RMCFG_SRC_IMPL;
        return impl[src] & fire[src];
    endfunction

    // Field extraction of a control word
    function automatic logic [2:0] trig_sel(input logic [31:0] ctl);
        return ctl[`RMCFG_CTL_TRIG_LSB +: 3];
    endfunction

    // ************************************************************
    // State
    // ************************************************************
    logic [15:0]             sel_q, sel_d;
    logic [31:0]             flt_q [NMON];    // R3
    logic [31:0]             flt_d [NMON];
    logic [31:0]             ctl_q [NMON];    // R3
    logic [31:0]             ctl_d [NMON];
    logic [31:0]             rdata_q, rdata_d;
    logic                    rvalid_q, rvalid_d;
    logic                    irq_q, irq_d;

    logic                    sel_ok;
    logic [`RMCFG_SEL_W-1:0] sel_idx;
    logic                    local_now;
    logic [NMON-1:0]         hit;
    logic [NMON-1:0]         cnt_wr;
    logic [NMON-1:0]         capt;
    logic [NMON-1:0]         wrap_w;
    logic [31:0]             count_w [NMON];
    logic [31:0]             snap_w [NMON];
    rmcfg_cfg_s              cfg_w [NMON];

    // ************************************************************
    // Decode
    // ************************************************************
    // Out of range selections reach no instance at all
    assign sel_ok    = (sel_q < 16'(NMON));
    assign sel_idx   = sel_q[`RMCFG_SEL_W-1:0];
    // Local trigger acts in the write cycle itself
    assign local_now = req_i.wr & (req_i.idx == `RMCFG_IDX_TRIGGER)
                     & req_i.wdata[`RMCFG_TRIG_NOW];              // R16

    // Per instance write hit, counter write and capture
    always_comb
    begin
        for (int i = 0; i < NMON; i++)
        begin
            hit[i]    = req_i.wr & sel_ok
                      & (sel_idx == `RMCFG_SEL_W'(i));            // R2
            cnt_wr[i] = hit[i] & (req_i.idx == `RMCFG_IDX_COUNT);
            capt[i]   = capt_hit(trig_sel(ctl_q[i]), ext_capture_i,
                                 local_now);                      // R15 R16
        end
    end

    // ************************************************************
    // Configuration registers
    // ************************************************************
    // Next values of select, filter and control words
    always_comb
    begin
        sel_d = sel_q;
        if (req_i.wr && req_i.idx == `RMCFG_IDX_SELECT)
            sel_d = req_i.wdata[15:0];
        for (int i = 0; i < NMON; i++)
        begin
            flt_d[i] = flt_q[i];
            ctl_d[i] = ctl_q[i];
            if (hit[i] && req_i.idx == `RMCFG_IDX_FILTER)
                flt_d[i] = req_i.wdata & `RMCFG_FLT_WMASK;        // R5 R6
            if (hit[i] && req_i.idx == `RMCFG_IDX_CONTROL)
                ctl_d[i] = req_i.wdata & `RMCFG_CTL_WMASK;        // R4 R10
            // An overflow in the clearing cycle still sets the flag
            ctl_d[i][`RMCFG_CTL_STICKY] = ctl_d[i][`RMCFG_CTL_STICKY]
                                        | wrap_w[i];              // R13
        end
    end

    // Register the configuration
    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            sel_q <= 16'h0000;
            for (int i = 0; i < NMON; i++)
            begin
                flt_q[i] <= `RMCFG_REG_RST;
                ctl_q[i] <= `RMCFG_REG_RST;
            end
        end
        else
        begin
            sel_q <= sel_d;
            for (int i = 0; i < NMON; i++)
            begin
                flt_q[i] <= flt_d[i];
                ctl_q[i] <= ctl_d[i];
            end
        end
    end

    // ************************************************************
    // Counters
    // ************************************************************
    // Each instance keeps its own count, so configuring one leaves
    // the collection in the others undisturbed
    for (genvar g = 0; g < NMON; g++)
    begin : g_mon
        assign cfg_w[g] = '{
            enable:      ctl_q[g][`RMCFG_CTL_ENABLE],
            part_en:     ctl_q[g][`RMCFG_CTL_PART_EN],
            group_en:    ctl_q[g][`RMCFG_CTL_GROUP_EN],
            freeze:      ctl_q[g][`RMCFG_CTL_FREEZE],
            clear_after: ctl_q[g][`RMCFG_CTL_CLEAR],
            part:        flt_q[g][15:0],
            group:       flt_q[g][23:16]
        };

        rmcfg_counter u_counter
        (
            .core_clk_i  (core_clk_i),
            .reset_n_i   (reset_n_i),
            .cfg_i       (cfg_w[g]),
            .evt_i       (evt_i),
            .sticky_i    (ctl_q[g][`RMCFG_CTL_STICKY]),
            .capture_i   (capt[g]),
            .cnt_wr_i    (cnt_wr[g]),
            .cnt_wdata_i (req_i.wdata),
            .count_o     (count_w[g]),
            .snap_o      (snap_w[g]),
            .wrap_o      (wrap_w[g])
        );
    end

    // ************************************************************
    // Read path and interrupt
    // ************************************************************
    // Read data one cycle after the request; unmapped reads give zero
    always_comb
    begin
        rdata_d  = 32'h0000_0000;
        rvalid_d = req_i.rd;
        irq_d    = 1'b0;
        if (req_i.rd)
        begin
            case (req_i.idx)
                `RMCFG_IDX_SELECT:
                    rdata_d = {16'h0000, sel_q};
                `RMCFG_IDX_FILTER:
                    rdata_d = sel_ok ? flt_q[sel_idx] : 32'h0000_0000;
                `RMCFG_IDX_CONTROL:
                    rdata_d = sel_ok ? (ctl_q[sel_idx]
                            | {24'h00_0000, `RMCFG_TYPE_BWU})   // R7
                            : 32'h0000_0000;
                `RMCFG_IDX_COUNT:
                    rdata_d = sel_ok ? count_w[sel_idx] : 32'h0000_0000;
                `RMCFG_IDX_CAPTURE:
                    rdata_d = sel_ok ? snap_w[sel_idx] : 32'h0000_0000;
                `RMCFG_IDX_IDENT:
                    rdata_d = 32'(NMON);                          // R1
                default:
                    rdata_d = 32'h0000_0000;
            endcase
        end
        // Interrupt only from instances that asked for it
        for (int i = 0; i < NMON; i++)
            irq_d = irq_d | (wrap_w[i] & ctl_q[i][`RMCFG_CTL_INTR]); // R12
    end

    // Register the answer and the interrupt pulse
    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            rdata_q  <= 32'h0000_0000;
            rvalid_q <= 1'b0;
            irq_q    <= 1'b0;
        end
        else
        begin
            rdata_q  <= rdata_d;
            rvalid_q <= rvalid_d;
            irq_q    <= irq_d;
        end
    end

    assign reg_rdata_o  = rdata_q;
    assign reg_rvalid_o = rvalid_q;
    assign wrap_irq_o   = irq_q;

    // ************************************************************
    // Checks
    // ************************************************************
    property p_type_const;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (req_i.rd && req_i.idx == `RMCFG_IDX_CONTROL && sel_ok)
            |=> (reg_rdata_o[7:0] == 8'h42) && reg_rvalid_o;
    endproperty
    a_type_const: assert property (p_type_const) // R7
        else $error("control type field wrong");

    property p_flt_rsvd;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (req_i.rd && req_i.idx == `RMCFG_IDX_FILTER)
            |=> (reg_rdata_o[31:24] == 8'h00);
    endproperty
    a_flt_rsvd: assert property (p_flt_rsvd) // R5
        else $error("filter reserved bits not zero");

    property p_extra_match_criteria_zero;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (req_i.rd && req_i.idx == `RMCFG_IDX_CONTROL)
            |=> (reg_rdata_o[23:20] == 4'h0) && (reg_rdata_o[15:8] == 8'h00);
    endproperty
    a_extra_match_criteria_zero: assert property (p_extra_match_criteria_zero) // R10
        else $error("unused control field not zero");

    property p_ident;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (req_i.rd && req_i.idx == `RMCFG_IDX_IDENT)
            |=> (reg_rdata_o[15:0] == 16'h0004);
    endproperty
    a_ident: assert property (p_ident) // R1
        else $error("instance count wrong");

    property p_sticky_set;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        wrap_w[0] |=> ctl_q[0][`RMCFG_CTL_STICKY];
    endproperty
    a_sticky_set: assert property (p_sticky_set) // R13
        else $error("overflow flag not set or lost");

    property p_irq_cause;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        wrap_irq_o |-> $past(|(wrap_w & {ctl_q[3][`RMCFG_CTL_INTR],
            ctl_q[2][`RMCFG_CTL_INTR], ctl_q[1][`RMCFG_CTL_INTR],
            ctl_q[0][`RMCFG_CTL_INTR]}));
    endproperty
    a_irq_cause: assert property (p_irq_cause) // R12
        else $error("interrupt without enabled overflow");

    property p_route;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (req_i.wr && req_i.idx == `RMCFG_IDX_FILTER && sel_ok
            && sel_idx != 2'd0) |=> $stable(flt_q[0]);
    endproperty
    a_route: assert property (p_route) // R2
        else $error("write reached an unselected instance");

    property p_bad_src;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (trig_sel(ctl_q[0]) inside {3'd2, 3'd3, 3'd4, 3'd5, 3'd6})
            |-> !capt[0];
    endproperty
    a_bad_src: assert property (p_bad_src) // R16
        else $error("unimplemented source captured");

endmodule
`default_nettype wire

// ### rmcfg_traffic.sv
// Traffic model: tagged memory-system requests toward the monitors.
// Assumes the bench changes its inputs just after a rising edge.
`timescale 1ns/1ps
`default_nettype none

module rmcfg_traffic
(
    // Request from the bench
    input  wire logic               fire_i,
    input  wire logic [15:0]        part_i,
    input  wire logic [7:0]         group_i,
    input  wire logic [7:0]         amount_i,
    // Request toward the monitors
    output var rmcfg_pkg::rmcfg_event_s evt_o
);
    import rmcfg_pkg::*;
    // Idle cycles show inverted tags so a stale tag never looks valid
    always_comb
    begin
        evt_o.valid  = fire_i;
        evt_o.part   = fire_i ? part_i : ~part_i;
        evt_o.group  = fire_i ? group_i : ~group_i;
        evt_o.amount = fire_i ? amount_i : ~amount_i;
    end
endmodule

`default_nettype wire

// ### resource_monitor_config_bench.sv
// Bench for the resource monitor bank: register port, matching,
// wrap, freeze and capture.
// Assumes rmcfg_map.svh on the include path, package compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "rmcfg_map.svh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
 mismatches++; $display("MISMATCH %s exp %h got %h", n, e, g); end end

module resource_monitor_config_bench;
    import rmcfg_pkg::*;
    // ************************************************************
    // Signals
    // ************************************************************
    logic         clk = 1'b0;
    logic         reset_n = 1'b0;
    rmcfg_req_s   req = '0;
    logic [1:0]   ext = 2'h0;
    logic         fire = 1'b0;
    logic [15:0]  part = 16'h0;
    logic [7:0]   grp = 8'h0;
    logic [7:0]   amt = 8'h0;
    rmcfg_event_s evt;
    logic [31:0]  rdata;
    logic         rvalid;
    logic         irq;
    int           mismatches = 0;
    int           check_count = 0;
    int           irq_seen = 0;
    logic [31:0]  seed = 32'h132B_3210;
    logic [31:0]  v;
    logic [31:0]  prev;
    logic [31:0]  ctl;
    logic [31:0]  exp_cnt;
    logic [2:0]   s;
    logic [1:0]   rt;
    logic [2:0]   srcs [4] = '{3'h0, 3'h1, 3'h7, 3'h2};

    // Core clock, 4 ns period
    always #2 clk = ~clk;
    // Overflow pulses are one cycle wide, so count them as they pass
    always @(posedge clk) if (irq === 1'b1) irq_seen++;

    rmcfg_top uut
    (
        .core_clk_i    (clk),
        .reset_n_i     (reset_n),
        .req_i         (req),
        .reg_rdata_o   (rdata),
        .reg_rvalid_o  (rvalid),
        .evt_i         (evt),
        .ext_capture_i (ext),
        .wrap_irq_o    (irq)
    );
    rmcfg_traffic partner
    (
        .fire_i   (fire),
        .part_i   (part),
        .group_i  (grp),
        .amount_i (amt),
        .evt_o    (evt)
    );

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // Bits 24 and 25 of r say whether the event tags were spoiled
    function automatic logic hit(input logic [31:0] c, input logic [31:0] r);
        return c[31] && !(c[16] && r[24]) && !(c[17] && r[25]);
    endfunction
    task automatic wr(input logic [2:0] i, input logic [31:0] d);
        @(posedge clk) req <= '{1'b1, 1'b0, i, d};
        @(posedge clk) req <= '0;
    endtask
    task automatic rc(input string n, input logic [2:0] i,
                      input logic [31:0] e);
        @(posedge clk) req <= '{1'b0, 1'b1, i, 32'h0};
        @(posedge clk) req <= '0;
        #1;
        `CHK("rvalid", 1'b1, rvalid)
        `CHK(n, e, rdata)
    endtask
    task automatic ev(input logic [15:0] p, input logic [7:0] g,
                      input logic [7:0] a);
        @(posedge clk) {fire, part, grp, amt} <= {1'b1, p, g, a};
        @(posedge clk) fire <= 1'b0;
    endtask
    // External pulses and a local trigger write in the same cycle
    task automatic pulse(input logic [1:0] e, input logic t);
        @(posedge clk) ext <= e;
        req <= '{t, 1'b0, `RMCFG_IDX_TRIGGER, 32'h1};
        @(posedge clk) ext <= 2'h0;
        req <= '0;
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // ************************************************************
    // Tests
    // ************************************************************
    initial
    begin
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        rc("ident", 3'h6, 32'h4);
        rc("ctl_reset", 3'h2, 32'h42);
        rc("unmapped", 3'h7, 32'h0);
        wr(3'h1, 32'hFFFF_FFFF);
        rc("flt_mask", 3'h1, 32'h00FF_FFFF);
        wr(3'h2, 32'h7FFF_FFFF);
        rc("ctl_mask", 3'h2, 32'h7F03_0042);
        wr(3'h2, 32'h0);
        rc("sticky_clr", 3'h2, 32'h42);
        wr(3'h0, 32'h1);
        wr(3'h1, 32'h0012_3456);
        wr(3'h0, 32'h5);
        rc("sel_out", 3'h1, 32'h0);
        wr(3'h0, 32'h0);
        rc("sel_0", 3'h1, 32'h00FF_FFFF);
        $display("test registers done");
        for (int k = 0; k < 8; k++)
        begin
            seed = lfsr(seed);
            ctl = {~k[2], 13'h0, k[1], k[0], 16'h0};
            exp_cnt = hit(ctl, seed) ? {24'h0, seed[31:24]} : 32'h0;
            wr(3'h2, ctl);
            wr(3'h1, {8'h0, seed[23:0]});
            wr(3'h3, 32'h0);
            ev(seed[15:0] ^ {15'h0, seed[24]},
               seed[23:16] ^ {7'h0, seed[25]}, seed[31:24]);
            rc("count", 3'h3, exp_cnt);
        end
        $display("test matching done");
        wr(3'h2, 32'h8300_0000);
        wr(3'h3, 32'h7FFF_FFFE);
        ev(16'h0, 8'h0, 8'h5);
        rc("wrap", 3'h3, 32'h3);
        rc("sticky", 3'h2, 32'h8700_0042);
        `CHK("irq", 1, irq_seen)
        ev(16'h0, 8'h0, 8'h5);
        rc("frozen", 3'h3, 32'h3);
        wr(3'h2, 32'h8000_0000);
        ev(16'h0, 8'h0, 8'h5);
        rc("resume", 3'h3, 32'h8);
        wr(3'h3, 32'h7FFF_FFFE);
        ev(16'h0, 8'h0, 8'h5);
        rc("rewrap", 3'h3, 32'h3);
        `CHK("no_irq", 1, irq_seen)
        $display("test overflow done");
        prev = 32'h0;
        for (int j = 0; j < 4; j++)
        begin
            s = srcs[j];
            rt = {s == 3'h1, s == 3'h0};
            seed = lfsr(seed);
            v = {1'b0, seed[30:0]};
            wr(3'h2, {1'b1, s, 1'b1, 27'h0});
            wr(3'h3, v);
            // A wrong source would clear the count before the right one
            pulse(~rt, s != 3'h7);
            pulse(rt, s == 3'h7);
            if (s != 3'h2) prev = v;
            rc("capture", 3'h4, prev);
            rc("cleared", 3'h3, (s == 3'h2) ? v : 32'h0);
        end
        $display("test capture done");
        complete_run();
    end

    // The tests need about two hundred cycles; this cuts a hang well past
    initial
    begin
        #40000;
        mismatches++;
        complete_run();
    end
endmodule

`default_nettype wire
